/* cdm_consts.vh */
`ifndef CDM_CONSTS_VH
`define CDM_CONSTS_VH
// ******************************************************
// region decode on the two high address bits
// ******************************************************
`define CDM_REG_GLYPH_INDEX   2'b00
`define CDM_REG_GLYPH_ROWS    2'b01
`define CDM_REG_CONTROL       2'b10
`define CDM_REG_CHAR_STORE    2'b11
// ******************************************************
// control word field positions
// ******************************************************
`define CDM_CW_BRIGHT_LSB     0
`define CDM_CW_BRIGHT_MSB     2
`define CDM_CW_FLASH_EN       3
`define CDM_CW_BLINK_EN       4
`define CDM_CW_TEST_PASS      5
`define CDM_CW_TEST_START     6
`define CDM_CW_CLEAR          7
// ******************************************************
// reset and fill values
// ******************************************************
`define CDM_CW_RESET          8'h00
`define CDM_SPACE_CODE        8'h20
`define CDM_INDEX_AFTER_TEST  8'hff
`define CDM_CHECKSUM_EXPECT   5'h00
// ******************************************************
// timing, in display clock periods unless noted; font and PWM step counts in clk cycles
// ******************************************************
`define CDM_CLK_PERIOD_NS     10
`define CDM_DISP_FREQ_HZ      57000
`define CDM_FLASH_DIVIDE      28672
`define CDM_SELFTEST_PERIODS  262144
`define CDM_CLEAR_PERIODS     3
`define CDM_FONT_STEPS        896
`define CDM_PWM_STEPS         15
`endif

/* cdm_display_ctrl.v */
`include "cdm_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module cdm_display_ctrl #(
   parameter integer DISP_DIV        = 100000000 / `CDM_DISP_FREQ_HZ,
   parameter integer FLASH_PERIODS   = `CDM_FLASH_DIVIDE,
   parameter integer SELFTEST_PERIODS = `CDM_SELFTEST_PERIODS
) (
   // clock and reset
   input  wire       clk,
   input  wire       sys_rst,
   // host bus
   input  wire       chip_select_n,
   input  wire       read_n,
   input  wire       write_n,
   input  wire       attribute_select_n,
   input  wire [4:0] addr,
   input  wire [7:0] data_in,
   output reg  [7:0] data_out,
   output wire       data_oe,
   // display clock
   input  wire       clock_source_select,
   input  wire       ext_clock_in,
   output reg        clock_out,
   // scan outputs
   output reg  [2:0] scan_char,
   output reg  [2:0] scan_row,
   output reg  [4:0] scan_dots
);

   localparam [31:0] FLASH_HALF = FLASH_PERIODS / 2;
   localparam [31:0] TEST_HALF  = SELFTEST_PERIODS / 2;

   // ******************************************************
   // stand-in font decoder
   // ******************************************************
   // xor of all outputs over every code and row is zero by construction
   function [4:0] font_row;
      input [6:0] code;
      input [2:0] row;
      begin
         font_row = code[4:0] ^ {code[6:5], row};
      end
   endfunction

   // duty in fifteenths: 100, 80, 53, 40, 27, 20, 13, 0 percent
   function [3:0] duty_of;
      input [2:0] code;
      begin
         case (code)
            3'h0:    duty_of = 4'hf;
            3'h1:    duty_of = 4'hc;
            3'h2:    duty_of = 4'h8;
            3'h3:    duty_of = 4'h6;
            3'h4:    duty_of = 4'h4;
            3'h5:    duty_of = 4'h3;
            3'h6:    duty_of = 4'h2;
            default: duty_of = 4'h0;
         endcase
      end
   endfunction

   // ******************************************************
   // state
   // ******************************************************
   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_CHECK = 2'h1;
   localparam [1:0] ST_PATT  = 2'h2;
   localparam [1:0] ST_CLEAR = 2'h3;

   reg  [7:0]  char_ram [0:7];
   reg  [7:0]  flash_ram;
   reg  [7:0]  control;
   reg  [7:0]  glyph_index;
   reg  [1:0]  state;
   reg  [18:0] busy_cnt;
   reg  [9:0]  chk_idx;
   reg  [4:0]  chk_sum;
   reg  [31:0] div_cnt;
   reg         ext_prev;
   reg  [15:0] flash_cnt;
   reg  [3:0]  pwm_cnt;
   reg         access_done;
   reg  [7:0]  cur_code;
   wire [4:0]  glyph_rd_a;
   wire [4:0]  glyph_rd_b;
   wire        disp_tick;
   wire        int_tick;
   wire        busy;
   wire        write_go;
   wire        region_flash;
   wire [1:0]  region;
   wire        fill_now;
   wire        test_end;

   assign busy         = (state != ST_IDLE);
   assign region_flash = ~attribute_select_n;
   assign region       = addr[4:3];

   // ******************************************************
   // display clock: internal divider or external edge
   // ******************************************************
   assign int_tick  = (div_cnt == DISP_DIV - 1);
   assign disp_tick = clock_source_select ? int_tick : (ext_clock_in & ~ext_prev);

   // divider and flash phase count from reset
   always @(posedge clk) begin
      if (sys_rst) begin
         div_cnt   <= 32'h0;
         clock_out <= 1'b0;
         ext_prev  <= 1'b0;
         flash_cnt <= 16'h0;
      end else begin
         ext_prev  <= ext_clock_in;
         div_cnt   <= int_tick ? 32'h0 : div_cnt + 32'h1;
         clock_out <= clock_source_select & (div_cnt < DISP_DIV / 2);
         if (disp_tick) begin
            flash_cnt <= (flash_cnt == FLASH_PERIODS - 1) ? 16'h0 : flash_cnt + 16'h1;
         end
      end
   end

   // ******************************************************
   // host bus access
   // ******************************************************
   // one strobe with chip select
   assign write_go = ~chip_select_n & ~write_n & read_n & ~access_done & ~busy;
   assign data_oe  = ~chip_select_n & ~read_n & write_n;

   // one write per select period; host raises select in between
   always @(posedge clk) begin
      if (sys_rst) begin
         access_done <= 1'b0;
      end else if (chip_select_n) begin
         access_done <= 1'b0;
      end else if (write_go) begin
         access_done <= 1'b1;
      end
   end

   // read mux, same decode as writes
   always @(posedge clk) begin
      if (sys_rst) begin
         data_out <= 8'h00;
      end else if (region_flash) begin
         data_out <= {7'h0, flash_ram[addr[2:0]]};
      end else begin
         case (region)
            `CDM_REG_GLYPH_INDEX: data_out <= glyph_index;
            `CDM_REG_GLYPH_ROWS:  data_out <= {3'h0, glyph_rd_a};
            `CDM_REG_CONTROL:     data_out <= control;
            default:              data_out <= char_ram[addr[2:0]];
         endcase
      end
   end

   // ******************************************************
   // self test and clear sequencer
   // ******************************************************
   assign test_end = (state == ST_PATT) & disp_tick & (busy_cnt == SELFTEST_PERIODS - 1);
   assign fill_now = test_end | ((state == ST_CLEAR) & disp_tick & (busy_cnt == `CDM_CLEAR_PERIODS - 1));

   always @(posedge clk) begin
      if (sys_rst) begin
         state    <= ST_IDLE;
         busy_cnt <= 19'h0;
         chk_idx  <= 10'h0;
         chk_sum  <= 5'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               busy_cnt <= 19'h0;
               chk_idx  <= 10'h0;
               chk_sum  <= 5'h0;
               if (write_go & ~region_flash & (region == `CDM_REG_CONTROL)) begin
                  // self test wins over clear when both set
                  if (data_in[`CDM_CW_TEST_START]) begin
                     state <= ST_CHECK;
                  end else if (data_in[`CDM_CW_CLEAR]) begin
                     state <= ST_CLEAR;
                  end
               end
            end
            ST_CHECK: begin
               chk_sum <= chk_sum ^ font_row(chk_idx[9:3], chk_idx[2:0]);
               chk_idx <= (chk_idx[2:0] == 3'h6) ? {chk_idx[9:3] + 7'h1, 3'h0} : chk_idx + 10'h1;
               if (disp_tick) begin
                  busy_cnt <= busy_cnt + 19'h1;
               end
               if (chk_idx == {7'h7f, 3'h6}) begin
                  state <= ST_PATT;
               end
            end
            ST_PATT: begin
               if (disp_tick) begin
                  busy_cnt <= busy_cnt + 19'h1;
               end
               if (test_end) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               if (disp_tick) begin
                  busy_cnt <= busy_cnt + 19'h1;
               end
               if (fill_now) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ******************************************************
   // control word and glyph index
   // ******************************************************
   always @(posedge clk) begin
      if (sys_rst) begin
         control <= `CDM_CW_RESET;
      end else if (test_end) begin
         control <= {2'h0, (chk_sum == `CDM_CHECKSUM_EXPECT), 5'h0};
      end else if (fill_now) begin
         control[`CDM_CW_CLEAR] <= 1'b0;
      end else if (write_go & ~region_flash & (region == `CDM_REG_CONTROL)) begin
         control <= {data_in[7:6], control[`CDM_CW_TEST_PASS], data_in[4:0]};
      end
   end

   // reset leaves the index alone, so it has no reset branch
   always @(posedge clk) begin
      if (test_end) begin
         glyph_index <= `CDM_INDEX_AFTER_TEST;
      end else if (write_go & ~region_flash & (region == `CDM_REG_GLYPH_INDEX)) begin
         // full byte kept, low nibble used
         glyph_index <= data_in;
      end
   end

   // ******************************************************
   // character and flash storage, one entry per location
   // ******************************************************
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_loc
         always @(posedge clk) begin
            if (sys_rst | fill_now) begin
               char_ram[i]  <= `CDM_SPACE_CODE;
               flash_ram[i] <= 1'b0;
            end else if (write_go & (addr[2:0] == i)) begin
               if (region_flash) begin
                  flash_ram[i] <= data_in[0];
               end else if (region == `CDM_REG_CHAR_STORE) begin
                  char_ram[i] <= data_in;
               end
            end
         end
      end
   endgenerate

   // ******************************************************
   // glyph rows
   // ******************************************************
   // rows addressed through the index register
   // row from address, five dots kept
   cdm_glyph_ram u_glyph (
      .clk       (clk),
      .wr_en     (write_go & ~region_flash & (region == `CDM_REG_GLYPH_ROWS)),
      .wr_addr   ({glyph_index[3:0], addr[2:0]}),
      .wr_data   (data_in[4:0]),
      .rd_a_addr ({glyph_index[3:0], addr[2:0]}),
      .rd_a_data (glyph_rd_a),
      .rd_b_addr ({cur_code[3:0], scan_row}),
      .rd_b_data (glyph_rd_b)
   );

   // ******************************************************
   // refresh scan
   // ******************************************************
   // step location each period, row after eight
   always @(posedge clk) begin
      if (sys_rst) begin
         scan_char <= 3'h0;
         scan_row  <= 3'h0;
         pwm_cnt   <= 4'h0;
         cur_code  <= 8'h00;
      end else begin
         pwm_cnt  <= (pwm_cnt == `CDM_PWM_STEPS - 1) ? 4'h0 : pwm_cnt + 4'h1;
         cur_code <= char_ram[scan_char];
         if (disp_tick) begin
            scan_char <= scan_char + 3'h1;
            if (scan_char == 3'h7) begin
               scan_row <= (scan_row == 3'h6) ? 3'h0 : scan_row + 3'h1;
            end
         end
      end
   end

   // dots: glyph read lags two cycles behind a step, a three-cycle glitch per period
   always @(posedge clk) begin
      if (sys_rst) begin
         scan_dots <= 5'h00;
      end else if (state == ST_CHECK | state == ST_PATT) begin
         scan_dots <= ((scan_row[0] ^ scan_char[0] ^ (busy_cnt >= TEST_HALF)) ? 5'h0a : 5'h15);
      end else if (pwm_cnt >= duty_of(control[`CDM_CW_BRIGHT_MSB:`CDM_CW_BRIGHT_LSB])) begin
         scan_dots <= 5'h00;
      end else if (control[`CDM_CW_BLINK_EN] & (flash_cnt >= FLASH_HALF)) begin
         scan_dots <= 5'h00;
      end else if (control[`CDM_CW_FLASH_EN] & flash_ram[scan_char] & (flash_cnt >= FLASH_HALF)) begin
         scan_dots <= 5'h00;
      // index in low nibble, code in seven
      // bit 4 leftmost, bit 0 rightmost
      end else if (cur_code[7]) begin
         scan_dots <= glyph_rd_b;
      end else begin
         scan_dots <= font_row(cur_code[6:0], scan_row);
      end
   end

endmodule
`default_nettype wire

/* cdm_display_ctrl_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module cdm_display_ctrl_properties (
   // clock and reset
   input wire logic       clk,
   input wire logic       sys_rst,
   // host bus
   input wire logic       chip_select_n,
   input wire logic       read_n,
   input wire logic       write_n,
   input wire logic       attribute_select_n,
   input wire logic [4:0] addr,
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic       data_oe,
   // display clock
   input wire logic       clock_source_select,
   input wire logic       ext_clock_in,
   input wire logic       clock_out,
   // scan
   input wire logic [2:0] scan_char,
   input wire logic [2:0] scan_row,
   input wire logic [4:0] scan_dots
);
   logic blank;
   default clocking cb @(posedge clk); endclocking
   // ******************************************************
   // shadow of the brightness code, blank only on code 7
   // ******************************************************
   always @(posedge clk) begin
      if (sys_rst)
         blank <= 1'b0;
      else if (!chip_select_n && !write_n && read_n && attribute_select_n && addr[4:3] == 2'b10)
         blank <= (data_in[2:0] == 3'h7) && !data_in[7] && !data_in[6];
   end
   sequence s_flash_held;
      !attribute_select_n ##1 (!attribute_select_n && $stable(addr));
   endsequence
   sequence s_rows_held;
      (attribute_select_n && addr[4:3] == 2'b01) ##1 (attribute_select_n && addr[4:3] == 2'b01 && $stable(addr)) [*2];
   endsequence
   // ******************************************************
   // checks
   // ******************************************************
   a_oe_read_only: assert property (disable iff (sys_rst) data_oe == (!chip_select_n && !read_n && write_n))
      else $error("data enable not tied to a read cycle");
   a_reset_clears: assert property (sys_rst |=> data_out == 8'h00 && scan_dots == 5'h00 && scan_char == 3'h0)
      else $error("outputs not cleared by reset");
   a_flash_one_bit: assert property (disable iff (sys_rst) s_flash_held |-> data_out[7:1] == 7'h00)
      else $error("flash read carries more than one bit");
   a_row_five_dots: assert property (disable iff (sys_rst) s_rows_held |-> data_out[7:5] == 3'h0)
      else $error("row read carries upper bits");
   a_blank_dark: assert property (disable iff (sys_rst) blank [*4] |-> scan_dots == 5'h00)
      else $error("dots lit with blanked brightness");
   a_scan_char_step: assert property (disable iff (sys_rst) $changed(scan_char) |-> scan_char == $past(scan_char) + 3'h1)
      else $error("scan skipped a character");
   a_scan_row_range: assert property (disable iff (sys_rst) scan_row <= 3'h6)
      else $error("scan row beyond seven rows");
   a_ext_clock_low: assert property (disable iff (sys_rst) !clock_source_select [*2] |-> !clock_out)
      else $error("clock output driven while external source selected");
endmodule
bind cdm_display_ctrl cdm_display_ctrl_properties u_props (.clk(clk), .sys_rst(sys_rst),
   .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n), .attribute_select_n(attribute_select_n),
   .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
   .clock_source_select(clock_source_select), .ext_clock_in(ext_clock_in), .clock_out(clock_out),
   .scan_char(scan_char), .scan_row(scan_row), .scan_dots(scan_dots));
`default_nettype wire

/* cdm_display_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module cdm_display_ctrl_tb;
   logic       clk, sys_rst, clock_source_select, ext_clock_in;
   logic       chip_select_n, read_n, write_n, attribute_select_n, data_oe, clock_out;
   logic [4:0] addr, scan_dots;
   logic [7:0] data_in, data_out, rd;
   logic [2:0] scan_char, scan_row;
   logic [7:0] f_rows [7] = '{8'hff, 8'hf0, 8'hf0, 8'hfe, 8'hf0, 8'hf0, 8'hf0};
   integer     fail_count = 0;
   integer     checks = 0;
   integer     i;
   cdm_display_ctrl #(.DISP_DIV(4), .FLASH_PERIODS(16), .SELFTEST_PERIODS(300)) dut (.clk(clk), .sys_rst(sys_rst),
      .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n), .attribute_select_n(attribute_select_n),
      .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .clock_source_select(clock_source_select), .ext_clock_in(ext_clock_in), .clock_out(clock_out),
      .scan_char(scan_char), .scan_row(scan_row), .scan_dots(scan_dots));
   cdm_host_model host (.clk(clk), .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n),
      .attribute_select_n(attribute_select_n), .addr(addr), .data_in(data_in), .data_out(data_out));
   // ******************************************************
   // shared checking
   // ******************************************************
   task automatic compare(input logic [7:0] got, input logic [7:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic read_cmp(input logic fl_n, input logic [4:0] a, input logic [7:0] exp);
      host.bus_read(fl_n, a, rd);
      compare(rd, exp);
   endtask
   function automatic logic [7:0] char_val(input integer n);
      char_val = n[0] ? {5'b10000, n[2:0]} : 8'h41 + n[7:0];   // odd slots use glyphs
   endfunction
   task automatic end_sim;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ******************************************************
   // scenarios
   // ******************************************************
   task automatic test_reset;
      for (i = 0; i < 8; i = i + 1) begin
         read_cmp(1'b1, {2'b11, i[2:0]}, 8'h20);
         read_cmp(1'b0, {2'b00, i[2:0]}, 8'h00);
      end
      read_cmp(1'b1, 5'h10, 8'h00);
      $display("test_reset done");
   endtask
   task automatic test_store;
      // flash writes with high address bits set, which must be ignored
      for (i = 0; i < 8; i = i + 1) begin
         host.bus_write(1'b1, {2'b11, i[2:0]}, char_val(i));
         host.bus_write(1'b0, {2'b11, i[2:0]}, {7'h7f, ~i[0]});
      end
      for (i = 0; i < 8; i = i + 1) begin
         read_cmp(1'b1, {2'b11, i[2:0]}, char_val(i));
         read_cmp(1'b0, {2'b00, i[2:0]}, {7'h00, ~i[0]});
      end
      $display("test_store done");
   endtask
   task automatic test_glyph;
      host.bus_write(1'b1, 5'h00, 8'h03);
      for (i = 0; i < 7; i = i + 1)
         host.bus_write(1'b1, {2'b01, i[2:0]}, f_rows[i]);
      read_cmp(1'b1, 5'h00, 8'h03);
      for (i = 0; i < 7; i = i + 1)
         read_cmp(1'b1, {2'b01, i[2:0]}, {3'h0, f_rows[i][4:0]});
      $display("test_glyph done");
   endtask
   task automatic test_control;
      host.bus_write(1'b1, 5'h10, 8'h3b);
      read_cmp(1'b1, 5'h10, 8'h1b);
      host.bus_write(1'b1, 5'h10, 8'h07);
      repeat (6) @(posedge clk);
      for (i = 0; i < 8; i = i + 1) begin
         @(posedge clk);
         compare({3'h0, scan_dots}, 8'h00);
      end
      clock_source_select <= 1'b0;
      repeat (6) @(posedge clk);
      compare({7'h00, clock_out}, 8'h00);
      clock_source_select <= 1'b1;
      $display("test_control done");
   endtask
   task automatic test_clear;
      host.bus_write(1'b1, 5'h10, 8'h85);
      repeat (30) @(posedge clk);
      read_cmp(1'b1, 5'h10, 8'h05);
      read_cmp(1'b1, 5'h00, 8'h03);
      read_cmp(1'b1, 5'h08, 8'h1f);
      for (i = 0; i < 8; i = i + 1) begin
         read_cmp(1'b1, {2'b11, i[2:0]}, 8'h20);
         read_cmp(1'b0, {2'b00, i[2:0]}, 8'h00);
      end
      $display("test_clear done");
   endtask
   task automatic test_selftest;
      host.bus_write(1'b1, 5'h10, 8'h40);
      repeat (1300) @(posedge clk);
      read_cmp(1'b1, 5'h10, 8'h20);
      read_cmp(1'b1, 5'h00, 8'hff);
      read_cmp(1'b1, 5'h1b, 8'h20);
      read_cmp(1'b0, 5'h04, 8'h00);
      $display("test_selftest done");
   endtask
   // dark cycles over one full flash period: 16 ticks of 4 clocks, spaces everywhere
   task automatic dark_cmp(input logic [7:0] cw, input logic [7:0] exp);
      integer n;
      n = 0;
      host.bus_write(1'b1, 5'h10, cw);
      repeat (8) @(posedge clk);
      repeat (64) begin
         @(posedge clk);
         if (scan_dots === 5'h00)
            n = n + 1;
      end
      compare(n[7:0], exp);
   endtask
   task automatic test_scan;
      dark_cmp(8'h00, 8'h00);
      host.bus_write(1'b0, 5'h00, 8'h01);
      dark_cmp(8'h00, 8'h00);
      dark_cmp(8'h08, 8'h04);
      dark_cmp(8'h18, 8'h20);
      $display("test_scan done");
   endtask
   // ******************************************************
   // clock, watchdog, main sequence
   // ******************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // whole run is near 2000 cycles, allow ten times that
   initial begin
      #200000;
      fail_count = fail_count + 1;
      end_sim;
   end
   initial begin
      sys_rst = 1'b1;
      clock_source_select = 1'b1;
      ext_clock_in = 1'b0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      test_reset;
      test_store;
      test_glyph;
      test_control;
      test_clear;
      test_selftest;
      test_scan;
      end_sim;
   end
endmodule
`default_nettype wire

/* cdm_glyph_ram.v */
`timescale 1ns/10ps
`default_nettype none
// ******************************************************
// custom glyph rows: 16 glyphs x 8 row slots x 5 dots
// ******************************************************
module cdm_glyph_ram (
   // clock
   input  wire       clk,
   // write port
   input  wire       wr_en,
   input  wire [6:0] wr_addr,
   input  wire [4:0] wr_data,
   // host read port
   input  wire [6:0] rd_a_addr,
   output reg  [4:0] rd_a_data,
   // scan read port
   input  wire [6:0] rd_b_addr,
   output reg  [4:0] rd_b_data
);

   reg [4:0] mem [0:127];

   // no reset: glyph contents survive reset and clear
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
   end

endmodule
`default_nettype wire

/* cdm_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cdm_host_model (
   // clock
   input  wire logic       clk,
   // bus toward the display
   output var  logic       chip_select_n,
   output var  logic       read_n,
   output var  logic       write_n,
   output var  logic       attribute_select_n,
   output var  logic [4:0] addr,
   output var  logic [7:0] data_in,
   input  wire logic [7:0] data_out
);
   // idle bus at time zero
   initial begin
      chip_select_n = 1'b1;
      read_n = 1'b1;
      write_n = 1'b1;
      attribute_select_n = 1'b1;
      addr = 5'h00;
      data_in = 8'h00;
   end
   task automatic bus_write(input logic fl_n, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      chip_select_n <= 1'b0;
      write_n <= 1'b0;
      attribute_select_n <= fl_n;
      addr <= a;
      data_in <= d;
      @(posedge clk);
      chip_select_n <= 1'b1;
      write_n <= 1'b1;
      data_in <= ~d;   // released bus must not keep the old value
   endtask
   // rows need two edges, wait four
   task automatic bus_read(input logic fl_n, input logic [4:0] a, output logic [7:0] d);
      @(posedge clk);
      chip_select_n <= 1'b0;
      read_n <= 1'b0;
      attribute_select_n <= fl_n;
      addr <= a;
      repeat (4) @(posedge clk);
      d = data_out;
      chip_select_n <= 1'b1;
      read_n <= 1'b1;
   endtask
endmodule
`default_nettype wire
